// ===== arb_pkg.sv
/*
  shared constants and types for the daisy chain arbitration ends.
  assumes a single 125 MHz clock domain on both ends.
*/
package arb_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned DELAY_WIDTH     = 16;
  localparam logic [15:0] DELAY_DEFAULT   = 16'h0010;
  localparam int unsigned SYNC_STAGES     = 2;
  // resource operation codes
  typedef enum logic [1:0] {
    op_test_type     = 2'h0,
    op_request_type  = 2'h1,
    op_set_type      = 2'h2,
    op_clear_type    = 2'h3
  } res_op_type;
  typedef enum logic [1:0] {
    rs_idle_type  = 2'b00,
    rs_wait_type  = 2'b01,
    rs_check_type = 2'b11
  } res_state_type;
  typedef enum logic [1:0] {
    bs_idle_type = 2'b00,
    bs_req_type  = 2'b01,
    bs_own_type  = 2'b11
  } bus_state_type;
endpackage : arb_pkg

// ===== arb_if.sv
/*
  link between the processor end and one requester end.
  assumes the testbench resolves wired lines from the enables.
*/
`timescale 1ns/1ns
interface arb_if;
  logic resource_busy_line;     // wired busy status seen by all users
  logic resource_req_line;      // request out of the processor end
  logic resource_grant_in;      // grant chain into the processor end
  logic resource_grant_out;     // grant chain out of the processor end
  logic cpu_bus_req_in;         // shared bus request level seen by cpu
  logic cpu_bus_grant_out;      // cpu acknowledge, head of bus chain
  logic shared_bus_req_line;    // resolved shared request line level
  logic bus_req_drive;          // requester drives request line active
  logic bus_grant_chain_in;     // bus grant into requester
  logic bus_grant_chain_out;    // bus grant out of requester
  logic res_req_o_line;         // requester resource request out
  logic res_grant_in_r;         // requester resource grant in
  logic res_grant_out_r;        // requester resource grant out
  modport cpu_mp (
    input  resource_busy_line, resource_grant_in, cpu_bus_req_in,
    output resource_req_line, resource_grant_out, cpu_bus_grant_out
  );
  modport req_mp (
    input  resource_busy_line, res_grant_in_r, shared_bus_req_line, bus_grant_chain_in,
    output res_req_o_line, res_grant_out_r, bus_req_drive, bus_grant_chain_out
  );
endinterface : arb_if

// ===== cpu_end.sv
/*
  processor end: resource request pins and operations, default bus master.
  assumes link inputs asynchronous; synchronises them on clk_i.
*/
`timescale 1ns/1ns
// Behaviour
// - sample busy before requesting, abort flagging busy
// - assert request, count 16-bit delay down
// - after delay test grant, flag or withdraw
// - chain grants only highest priority requester
// - four one-way resource lines per user
// - no preemption, hold until request released
// - one request output, one readable state input
// - test, timed request, set, clear operations
// - processor is default bus master
// - finish cycle, float, then acknowledge bus
// - bus request line sensed and driven by all; cpu end only senses it, req_end drives it
// - requester waits while bus line active
// - idle line: drive request, await grant
// - granted requester blocks grant, takes bus
module cpu_end (
  input  wire logic                 clk_i,        // 125 MHz clock
  input  wire logic                 reset_n_i,    // async reset, active low
  arb_if.cpu_mp                     link,         // link side
  input  wire logic                 op_valid_i,   // operation strobe
  input  wire arb_pkg::res_op_type  op_code_i,    // operation select
  input  wire logic [15:0]          op_delay_i,   // delay count for timed request
  input  wire logic                 cycle_end_i,  // current machine cycle ends
  output logic                      busy_o,       // op in progress
  output logic                      done_o,       // op finished pulse
  output logic                      res_state_o,  // last tested resource input
  output logic                      busy_flag_o,  // request ended: resource busy
  output logic                      grant_flag_o, // resource granted
  output logic                      bus_float_o,  // outputs floated
  output logic                      bus_master_o  // processor drives bus
);
  import arb_pkg::*;
  logic [1:0]    busy_sync_ff;
  logic [1:0]    grant_sync_ff;
  logic [1:0]    breq_sync_ff;
  logic [15:0]   cnt_ff;
  res_state_type state_ff;
  logic          req_ff;
  logic          gout_ff;
  logic          busy_ff;
  logic          done_ff;
  logic          rstate_ff;
  logic          bflag_ff;
  logic          gflag_ff;
  logic          float_ff;
  logic          ack_ff;
  // registered copy of the inverse of float so the output comes from a flop
  logic          master_ff;
  wire busy_s  = busy_sync_ff[1];
  wire grant_s = grant_sync_ff[1];
  wire breq_s  = breq_sync_ff[1];
  wire start   = op_valid_i && state_ff == rs_idle_type;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_sync_ff  <= 2'h0;
      grant_sync_ff <= 2'h0;
      breq_sync_ff  <= 2'h0;
    end else begin
      busy_sync_ff  <= {busy_sync_ff[0], link.resource_busy_line};
      grant_sync_ff <= {grant_sync_ff[0], link.resource_grant_in};
      breq_sync_ff  <= {breq_sync_ff[0], link.cpu_bus_req_in};
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= rs_idle_type;
      cnt_ff <= 16'h0000;
      req_ff <= 1'b0;
      done_ff <= 1'b0;
      rstate_ff <= 1'b0;
      bflag_ff <= 1'b0;
      gflag_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        rs_idle_type: if (start) begin
          unique case (op_code_i)
            op_test_type: begin
              rstate_ff <= busy_s;
              done_ff <= 1'b1;
            end
            op_request_type: begin
              if (busy_s) begin
                bflag_ff <= 1'b1;
                gflag_ff <= 1'b0;
                done_ff <= 1'b1;
              end else begin
                req_ff <= 1'b1;
                bflag_ff <= 1'b0;
                cnt_ff <= op_delay_i;
                state_ff <= rs_wait_type;
                busy_ff <= 1'b1;
              end
            end
            op_set_type: begin
              req_ff <= 1'b1;
              done_ff <= 1'b1;
            end
            op_clear_type: begin
              req_ff <= 1'b0;
              gflag_ff <= 1'b0;
              done_ff <= 1'b1;
            end
          endcase
        end
        rs_wait_type: begin
          if (cnt_ff == 16'h0000) state_ff <= rs_check_type;
          else cnt_ff <= cnt_ff - 16'h0001;
        end
        rs_check_type: begin
          gflag_ff <= grant_s;
          req_ff <= grant_s;
          done_ff <= 1'b1;
          state_ff <= rs_idle_type;
          busy_ff <= 1'b0;
        end
        default: begin
          state_ff <= rs_idle_type;
          busy_ff <= 1'b0;
        end
      endcase
    end
  end
  // grant passes on only while not requesting
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) gout_ff <= 1'b0;
    else gout_ff <= grant_s && !req_ff;
  end
  // bus: float at end of cycle, then acknowledge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      float_ff <= 1'b0;
      master_ff <= 1'b1;
      ack_ff <= 1'b0;
    end else if (!breq_s) begin
      float_ff <= 1'b0;
      master_ff <= 1'b1;
      ack_ff <= 1'b0;
    end else begin
      if (cycle_end_i) begin
        float_ff <= 1'b1;
        master_ff <= 1'b0;
      end
      ack_ff <= float_ff;
    end
  end
  assign link.resource_req_line  = req_ff;
  assign link.resource_grant_out = gout_ff;
  assign link.cpu_bus_grant_out  = ack_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign res_state_o = rstate_ff;
  assign busy_flag_o = bflag_ff;
  assign grant_flag_o = gflag_ff;
  assign bus_float_o = float_ff;
  assign bus_master_o = master_ff;
endmodule : cpu_end

// ===== req_end.sv
/*
  bus and resource requester end of the daisy chains.
  assumes chain inputs asynchronous; synchronised here.
*/
`timescale 1ns/1ns
module req_end (
  input  wire logic clk_i,        // 125 MHz clock
  input  wire logic reset_n_i,    // async reset, active low
  arb_if.req_mp     link,         // link side
  input  wire logic bus_want_i,   // user wants the bus
  input  wire logic res_want_i,   // user wants the resource
  output logic      bus_owner_o,  // bus taken
  output logic      res_owner_o   // resource held
);
  import arb_pkg::*;
  logic [1:0] bsy_sync_ff, rgi_sync_ff, lreq_sync_ff, bgi_sync_ff;
  bus_state_type bstate_ff;
  logic drive_ff, bgo_ff, rreq_ff, rgo_ff, rown_ff, own_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bsy_sync_ff <= 2'h0;
      rgi_sync_ff <= 2'h0;
      lreq_sync_ff <= 2'h0;
      bgi_sync_ff <= 2'h0;
    end else begin
      bsy_sync_ff <= {bsy_sync_ff[0], link.resource_busy_line};
      rgi_sync_ff <= {rgi_sync_ff[0], link.res_grant_in_r};
      lreq_sync_ff <= {lreq_sync_ff[0], link.shared_bus_req_line};
      bgi_sync_ff <= {bgi_sync_ff[0], link.bus_grant_chain_in};
    end
  end
  wire lreq_s = lreq_sync_ff[1];
  wire bgi_s = bgi_sync_ff[1];
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bstate_ff <= bs_idle_type;
      drive_ff <= 1'b0;
      bgo_ff <= 1'b0;
      own_ff <= 1'b0;
    end else begin
      unique case (bstate_ff)
        bs_idle_type: begin
          bgo_ff <= bgi_s;
          if (bus_want_i && !lreq_s) begin
            drive_ff <= 1'b1;
            bgo_ff <= 1'b0;
            bstate_ff <= bs_req_type;
          end
        end
        bs_req_type: begin
          bgo_ff <= 1'b0;
          if (bgi_s) begin
            bstate_ff <= bs_own_type;
            own_ff <= 1'b1;
          end
        end
        bs_own_type: if (!bus_want_i) begin
          drive_ff <= 1'b0;
          own_ff <= 1'b0;
          bstate_ff <= bs_idle_type;
        end
        default: bstate_ff <= bs_idle_type;
      endcase
    end
  end
  // resource side: simple hold while wanted; grant blocked while requesting
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rreq_ff <= 1'b0;
      rgo_ff <= 1'b0;
      rown_ff <= 1'b0;
    end else begin
      if (!res_want_i) rreq_ff <= 1'b0;
      else if (!bsy_sync_ff[1] && !rreq_ff) rreq_ff <= 1'b1;
      rgo_ff <= rgi_sync_ff[1] && !rreq_ff;
      rown_ff <= rreq_ff && rgi_sync_ff[1] && res_want_i;
    end
  end
  assign link.bus_req_drive = drive_ff;
  assign link.bus_grant_chain_out = bgo_ff;
  assign link.res_req_o_line = rreq_ff;
  assign link.res_grant_out_r = rgo_ff;
  assign bus_owner_o = own_ff;
  assign res_owner_o = rown_ff;
endmodule : req_end

// ===== daisy_chain_arbitration_asserts.sv
/* link checker for the processor end and the requester end.
   assumes wired lines are resolved by the bench. */
`timescale 1ns/1ns
module daisy_chain_arbitration_asserts (
  input wire logic clk_i,               // clock
  input wire logic reset_n_i,           // reset, low
  input wire logic cpu_bus_req_in,      // cpu request
  input wire logic cpu_bus_grant_out,   // cpu ack
  input wire logic shared_bus_req_line, // wired line
  input wire logic bus_req_drive,       // requester drive
  input wire logic bus_grant_chain_in,  // grant in
  input wire logic bus_grant_chain_out, // grant out
  input wire logic resource_busy_line,  // busy line
  input wire logic resource_req_line,   // cpu resource request
  input wire logic resource_grant_in,   // cpu grant in
  input wire logic resource_grant_out,  // cpu grant out
  input wire logic res_req_o_line       // requester resource request
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_ack_cause; $rose(cpu_bus_grant_out) |-> $past(cpu_bus_req_in, 2); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_ack_bound; $rose(cpu_bus_req_in) |-> ##[3:16] cpu_bus_grant_out; endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack late");
  property p_ack_drop; (!cpu_bus_req_in)[*4] |-> !cpu_bus_grant_out; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack held");
  property p_bus_block;
    (bus_req_drive && bus_grant_chain_in)[*2] |-> !bus_grant_chain_out;
  endproperty
  a_bus_block: assert property (p_bus_block) else $error("grant passed on");
  property p_bus_pass;
    (!bus_req_drive && bus_grant_chain_in)[*5] |-> bus_grant_chain_out;
  endproperty
  a_bus_pass: assert property (p_bus_pass) else $error("grant not passed");
  property p_no_preempt; $rose(bus_req_drive) |-> !$past(shared_bus_req_line); endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("drive on busy line");
  property p_res_block;
    (resource_req_line && resource_grant_in)[*4] |-> !resource_grant_out;
  endproperty
  a_res_block: assert property (p_res_block) else $error("resource grant passed");
  property p_res_busy; $rose(res_req_o_line) |-> !$past(resource_busy_line); endproperty
  a_res_busy: assert property (p_res_busy) else $error("request on busy");
endmodule : daisy_chain_arbitration_asserts

// ===== daisy_chain_arbitration_bench.sv
/* bench joining the processor end and the requester end.
   assumes nothing outside the two ends and the link. */
`timescale 1ns/1ns
module daisy_chain_arbitration_bench;
  import arb_pkg::*;
  logic       clk_i = 0, reset_n_i = 0, op_valid_i = 0, cycle_end_i = 0;
  logic       bus_want_i = 0, res_want_i = 0, res_head = 1, other_req = 0;
  res_op_type op_code_i = op_test_type;
  logic [15:0] op_delay_i = 16'h0010;
  logic [1:0] phase_ff = 2'h0;
  logic       busy_o, done_o, res_state_o, busy_flag_o, grant_flag_o, bus_float_o;
  logic       bus_master_o, bus_owner_o, res_owner_o;
  int         n_fail = 0, check_count = 0;
  wire logic [2:0] watch = {bus_master_o, bus_owner_o, done_o};
  arb_if lk ();
  assign lk.resource_busy_line = lk.resource_req_line | lk.res_req_o_line;
  assign lk.resource_grant_in = res_head;
  assign lk.res_grant_in_r = lk.resource_grant_out;
  assign lk.shared_bus_req_line = lk.bus_req_drive | other_req;
  assign lk.cpu_bus_req_in = lk.bus_req_drive | other_req;
  assign lk.bus_grant_chain_in = lk.cpu_bus_grant_out;
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    phase_ff <= phase_ff + 2'h1;
    cycle_end_i <= (phase_ff == 2'h2);
  end
  cpu_end i_cpu_end (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(lk), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_delay_i(op_delay_i), .cycle_end_i(cycle_end_i), .busy_o(busy_o),
    .done_o(done_o), .res_state_o(res_state_o), .busy_flag_o(busy_flag_o),
    .grant_flag_o(grant_flag_o), .bus_float_o(bus_float_o), .bus_master_o(bus_master_o));
  req_end i_req_end (.clk_i(clk_i), .reset_n_i(reset_n_i), .link(lk), .bus_want_i(bus_want_i),
    .res_want_i(res_want_i), .bus_owner_o(bus_owner_o), .res_owner_o(res_owner_o));
  daisy_chain_arbitration_asserts i_daisy_chain_arbitration_asserts (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .cpu_bus_req_in(lk.cpu_bus_req_in),
    .cpu_bus_grant_out(lk.cpu_bus_grant_out), .shared_bus_req_line(lk.shared_bus_req_line),
    .bus_req_drive(lk.bus_req_drive), .bus_grant_chain_in(lk.bus_grant_chain_in),
    .bus_grant_chain_out(lk.bus_grant_chain_out), .resource_busy_line(lk.resource_busy_line),
    .resource_req_line(lk.resource_req_line), .resource_grant_in(lk.resource_grant_in),
    .resource_grant_out(lk.resource_grant_out), .res_req_o_line(lk.res_req_o_line));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic check(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle
  task automatic wait_for(input int sel, input logic v);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      #1;
      if (watch[sel] === v) return;
    end
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    wrap_up();
  endtask : wait_for
  task automatic do_op(input res_op_type c, input logic [15:0] d);
    @(posedge clk_i);
    op_code_i  <= c;
    op_delay_i <= d;
    op_valid_i <= 1'b1;
    @(posedge clk_i);
    op_valid_i <= 1'b0;
    #1;
    // done_o stands one cycle only, so look right after the taking edge
    if (done_o !== 1'b1) begin
      check(busy_o, 1'b1, "op not busy");
      wait_for(0, 1'b1);
    end
  endtask : do_op
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    idle(4);
    check(bus_master_o, 1'b1, "cpu not master");
    do_op(op_test_type, 16'h0000);
    check(res_state_o, 1'b0, "free read as busy");
    @(posedge clk_i) res_want_i <= 1'b1;
    idle(16);
    check(res_owner_o, 1'b1, "requester not granted");
    do_op(op_test_type, 16'h0000);
    check(res_state_o, 1'b1, "busy not seen");
    do_op(op_request_type, 16'h0010);
    check(busy_flag_o, 1'b1, "busy not flagged");
    check(lk.resource_req_line, 1'b0, "request on busy");
    @(posedge clk_i) res_want_i <= 1'b0;
    idle(8);
    do_op(op_request_type, 16'h0010);
    check(grant_flag_o, 1'b1, "free resource refused");
    check(lk.resource_req_line, 1'b1, "request dropped");
    @(posedge clk_i) res_want_i <= 1'b1;
    idle(16);
    check(res_owner_o, 1'b0, "holder preempted");
    check(lk.res_grant_in_r, 1'b0, "grant passed by holder");
    do_op(op_clear_type, 16'h0000);
    check(lk.resource_req_line, 1'b0, "clear kept request");
    idle(16);
    check(res_owner_o, 1'b1, "release not seen");
    do_op(op_set_type, 16'h0000);
    check(lk.resource_req_line, 1'b1, "set failed");
    do_op(op_clear_type, 16'h0000);
    @(posedge clk_i) res_want_i <= 1'b0;
    res_head <= 1'b0;
    idle(8);
    do_op(op_request_type, 16'h0004);
    check(grant_flag_o, 1'b0, "grant without chain");
    check(lk.resource_req_line, 1'b0, "failed request kept");
    @(posedge clk_i) bus_want_i <= 1'b1;
    wait_for(1, 1'b1);
    check(bus_float_o, 1'b1, "bus not floated");
    check(lk.bus_grant_chain_out, 1'b0, "bus grant passed");
    @(posedge clk_i) bus_want_i <= 1'b0;
    wait_for(2, 1'b1);
    @(posedge clk_i) other_req <= 1'b1;
    wait_for(2, 1'b0);
    @(posedge clk_i) bus_want_i <= 1'b1;
    idle(16);
    check(lk.bus_req_drive, 1'b0, "drove busy line");
    check(lk.bus_grant_chain_out, 1'b1, "grant not passed");
    @(posedge clk_i) other_req <= 1'b0;
    wait_for(1, 1'b1);
    @(posedge clk_i) bus_want_i <= 1'b0;
    wait_for(2, 1'b1);
    wrap_up();
  end
endmodule : daisy_chain_arbitration_bench
